// file: src/amd_mode_decode.sv
// Operation
// - Enable and sync polarity pins high or floating: shared pin is range select or alt enable.
// - As full-scale select, shared pin low picks the reduced range and high the larger range.
// - Shared pin floating or mid enables extended control with serial port and registers.
// - Dedicated enable pin wins over the alternate enable on the shared pin when they disagree.
// - Sync polarity pin low makes the shared pin the negative leg of the sync pulse.
// - In differential sync mode the range is not pin controlled and is the larger range.
// - With the shared pin firm high or low, the calibration-delay pin picks the power-up delay.
// - Shared pin floating with single-ended sync makes the calibration-delay pin a chip select and the delay short.
// - Calibration-delay pin mid selects dual-edge sampling.
// - Samples are taken on the falling edge of the positive sample clock leg.
// - Range follows the select pin in normal mode and the adjust register in extended mode.
// - Dedicated enable pin high gives pin-only control; low makes extended control active.
// - Sync polarity pin floating or high picks a single-ended sync pulse; low differential.
`default_nettype none
module amd_mode_decode
   import amd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // dedicated extended-control enable pin comparators
   input wire logic extended_ctl_enable_hi,
   input wire logic extended_ctl_enable_lo,
   // sync polarity select pin comparators
   input wire logic sync_polarity_select_hi,
   input wire logic sync_polarity_select_lo,
   // shared full-scale / alternate enable / sync negative pin comparators
   input wire logic full_scale_select_hi,
   input wire logic full_scale_select_lo,
   // calibration delay / dual edge / chip select pin comparators
   input wire logic cal_delay_select_hi,
   input wire logic cal_delay_select_lo,
   // positive leg of the sample clock
   input wire logic sample_clk_p,
   // full-scale voltage adjust register contents
   input wire logic [AMD_FS_ADJ_W-1:0] fs_adjust_reg,
   // extended control state
   output logic ext_ctl_active,
   output logic alt_extended_ctl_enable,
   // full-scale range
   output logic fs_range_high,
   output logic fs_use_register,
   output logic [AMD_FS_ADJ_W-1:0] fs_adjust,
   // output-clock sync
   output logic sync_differential,
   output logic out_clock_sync_neg,
   // calibration and serial select
   output logic cal_delay_long,
   output logic serial_chip_select_n,
   // sampling
   output logic dual_edge_sampling,
   output logic sample_take
);

   // ****************************************
   // pin resolution
   // ****************************************
   amd_level_t ext_en_lvl;
   amd_level_t sps_lvl;
   amd_level_t fs_lvl;
   amd_level_t cal_lvl;

   // each three-level pin gets its own synchroniser and resolver
   amd_tri_level u_ext_en (.clk(clk), .rstn(rstn), .pin_above_hi(extended_ctl_enable_hi),
      .pin_below_lo(extended_ctl_enable_lo), .level(ext_en_lvl));
   amd_tri_level u_sps (.clk(clk), .rstn(rstn), .pin_above_hi(sync_polarity_select_hi),
      .pin_below_lo(sync_polarity_select_lo), .level(sps_lvl));
   amd_tri_level u_fs (.clk(clk), .rstn(rstn), .pin_above_hi(full_scale_select_hi),
      .pin_below_lo(full_scale_select_lo), .level(fs_lvl));
   amd_tri_level u_cal (.clk(clk), .rstn(rstn), .pin_above_hi(cal_delay_select_hi),
      .pin_below_lo(cal_delay_select_lo), .level(cal_lvl));

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [AMD_SCLK_W-1:0] sclk_sync;
      logic ext_active;
      logic alt_en;
      logic fs_high;
      logic fs_use_reg;
      logic [AMD_FS_ADJ_W-1:0] fs_adj;
      logic sync_diff;
      logic sync_neg;
      logic cal_long;
      logic cs_n;
      logic des;
      logic take;
   } amd_state_t;

   amd_state_t state_reg;
   amd_state_t state_next;
   logic alt_mode;
   logic cs_mode;

   // mode priority and pin function decode
   always_comb begin
      state_next = state_reg;
      // sample clock: two sync flops then a history flop for edge detect
      state_next.sclk_sync = {state_reg.sclk_sync[1:0], sample_clk_p};
      state_next.take = state_reg.sclk_sync[2] & ~state_reg.sclk_sync[1];
      // sync polarity pin low selects differential sync
      state_next.sync_diff = (sps_lvl == AMD_LVL_LOW);
      // shared pin is select/alternate enable unless sync is differential
      alt_mode = (sps_lvl != AMD_LVL_LOW);
      state_next.alt_en = alt_mode && (fs_lvl == AMD_LVL_MID);
      // dedicated pin decides when firm; floating defers to the shared pin
      unique case (ext_en_lvl)
         AMD_LVL_LOW: state_next.ext_active = AMD_ON;
         AMD_LVL_HIGH: state_next.ext_active = AMD_OFF;
         default: state_next.ext_active = state_next.alt_en;
      endcase
      // pin-controlled range; differential sync forces the larger range
      if (!alt_mode) begin
         state_next.fs_high = AMD_ON;
      end else begin
         state_next.fs_high = (fs_lvl != AMD_LVL_LOW);
      end
      // extended mode hands the range to the adjust register
      state_next.fs_use_reg = state_next.ext_active;
      state_next.fs_adj = state_next.ext_active ? fs_adjust_reg : AMD_FS_ADJ_RST;
      // negative leg of the differential sync pulse
      state_next.sync_neg = !alt_mode && (fs_lvl == AMD_LVL_HIGH);
      // floating shared pin with single-ended sync turns calibration delay into chip select
      cs_mode = alt_mode && (fs_lvl == AMD_LVL_MID);
      state_next.cal_long = !cs_mode && (cal_lvl == AMD_LVL_HIGH);
      state_next.cs_n = cs_mode ? (cal_lvl != AMD_LVL_LOW) : AMD_ON;
      state_next.des = (cal_lvl == AMD_LVL_MID);
   end

   // state register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg.sclk_sync <= AMD_SCLK_RST;
         state_reg.ext_active <= AMD_OFF;
         state_reg.alt_en <= AMD_OFF;
         state_reg.fs_high <= AMD_ON;
         state_reg.fs_use_reg <= AMD_OFF;
         state_reg.fs_adj <= AMD_FS_ADJ_RST;
         state_reg.sync_diff <= AMD_OFF;
         state_reg.sync_neg <= AMD_OFF;
         state_reg.cal_long <= AMD_OFF;
         state_reg.cs_n <= AMD_ON;
         state_reg.des <= AMD_OFF;
         state_reg.take <= AMD_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // every output comes straight from a flop
   assign ext_ctl_active = state_reg.ext_active;
   assign alt_extended_ctl_enable = state_reg.alt_en;
   assign fs_range_high = state_reg.fs_high;
   assign fs_use_register = state_reg.fs_use_reg;
   assign fs_adjust = state_reg.fs_adj;
   assign sync_differential = state_reg.sync_diff;
   assign out_clock_sync_neg = state_reg.sync_neg;
   assign cal_delay_long = state_reg.cal_long;
   assign serial_chip_select_n = state_reg.cs_n;
   assign dual_edge_sampling = state_reg.des;
   assign sample_take = state_reg.take;

   // ****************************************
   // checks
   // ****************************************
   alt_enable_a: assert property (@(posedge clk) disable iff (!rstn)
      (sps_lvl != AMD_LVL_LOW && fs_lvl == AMD_LVL_MID && ext_en_lvl == AMD_LVL_MID)
      |=> ext_ctl_active && alt_extended_ctl_enable)
      else $error("floating shared pin did not enable extended control");
   ext_priority_a: assert property (@(posedge clk) disable iff (!rstn)
      (ext_en_lvl == AMD_LVL_HIGH) |=> !ext_ctl_active)
      else $error("dedicated enable pin high did not disable extended control");
   ext_low_a: assert property (@(posedge clk) disable iff (!rstn)
      (ext_en_lvl == AMD_LVL_LOW) |=> ext_ctl_active && fs_use_register)
      else $error("dedicated enable pin low did not activate extended control");
   fs_select_a: assert property (@(posedge clk) disable iff (!rstn)
      (sps_lvl != AMD_LVL_LOW && fs_lvl != AMD_LVL_MID)
      |=> fs_range_high == $past(fs_lvl == AMD_LVL_HIGH))
      else $error("full-scale range does not follow the select pin");
   diff_range_a: assert property (@(posedge clk) disable iff (!rstn)
      (sps_lvl == AMD_LVL_LOW) |=> fs_range_high && sync_differential)
      else $error("differential sync mode did not force the larger range");
   alt_mode_a: assert property (@(posedge clk) disable iff (!rstn)
      (sps_lvl == AMD_LVL_LOW) |=> !alt_extended_ctl_enable && serial_chip_select_n)
      else $error("shared pin kept its select role in differential sync mode");
   sync_neg_a: assert property (@(posedge clk) disable iff (!rstn)
      (sps_lvl == AMD_LVL_LOW) |=> out_clock_sync_neg == $past(fs_lvl == AMD_LVL_HIGH))
      else $error("negative sync leg does not follow the shared pin");
   sync_mode_a: assert property (@(posedge clk) disable iff (!rstn)
      $past(rstn) |-> sync_differential == $past(sps_lvl == AMD_LVL_LOW))
      else $error("sync mode does not follow the polarity pin");
   chip_select_a: assert property (@(posedge clk) disable iff (!rstn)
      (sps_lvl != AMD_LVL_LOW && fs_lvl == AMD_LVL_MID)
      |=> !cal_delay_long && serial_chip_select_n == $past(cal_lvl != AMD_LVL_LOW))
      else $error("chip select mode wrong or delay not short");
   cal_delay_a: assert property (@(posedge clk) disable iff (!rstn)
      (fs_lvl != AMD_LVL_MID)
      |=> serial_chip_select_n && cal_delay_long == $past(cal_lvl == AMD_LVL_HIGH))
      else $error("calibration delay does not follow its pin");
   des_mode_a: assert property (@(posedge clk) disable iff (!rstn)
      $past(rstn) |-> dual_edge_sampling == $past(cal_lvl == AMD_LVL_MID))
      else $error("dual-edge sampling does not follow the mid level");
   sample_edge_a: assert property (@(posedge clk) disable iff (!rstn)
      $fell(state_reg.sclk_sync[1]) |=> sample_take ##1 !sample_take)
      else $error("falling sample clock edge not marked by a single pulse");
   reg_range_a: assert property (@(posedge clk) disable iff (!rstn)
      ext_ctl_active |-> fs_adjust == $past(fs_adjust_reg))
      else $error("adjust value does not follow the register in extended mode");
   level_track_a: assert property (@(posedge clk) disable iff (!rstn)
      $past(rstn, 3) |-> (fs_lvl == AMD_LVL_HIGH)
      == ($past(full_scale_select_hi, 3) && !$past(full_scale_select_lo, 3)))
      else $error("shared pin level does not follow its comparators");

endmodule // amd_mode_decode
`default_nettype wire

// file: src/amd_pkg.sv
`default_nettype none
package amd_pkg;

   // ****************************************
   // resolved state of a three-level pin
   // ****************************************
   // gray order along low -> mid -> high; code 2'b10 is never produced
   typedef enum logic [1:0] {
      AMD_LVL_LOW = 2'b00,
      AMD_LVL_MID = 2'b01,
      AMD_LVL_HIGH = 2'b11
   } amd_level_t;

   // ****************************************
   // widths and reset values
   // ****************************************
   localparam int AMD_FS_ADJ_W = 8;
   localparam int AMD_SYNC_W = 2;
   localparam int AMD_SCLK_W = 3;
   localparam logic [AMD_SYNC_W-1:0] AMD_SYNC_RST = 2'h0;
   localparam logic [AMD_SCLK_W-1:0] AMD_SCLK_RST = 3'h0;
   localparam logic [AMD_FS_ADJ_W-1:0] AMD_FS_ADJ_RST = 8'h00;
   localparam logic AMD_OFF = 1'b0;
   localparam logic AMD_ON = 1'b1;

endpackage : amd_pkg
`default_nettype wire

// file: src/amd_tri_level.sv
`default_nettype none
module amd_tri_level
   import amd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // comparator outputs of one pin
   input wire logic pin_above_hi,
   input wire logic pin_below_lo,
   // resolved pin state
   output amd_level_t level
);

   typedef struct packed {
      logic [AMD_SYNC_W-1:0] hi_sync;
      logic [AMD_SYNC_W-1:0] lo_sync;
      amd_level_t level;
   } amd_tri_state_t;

   amd_tri_state_t state_reg;
   amd_tri_state_t state_next;

   // two-flop synchronisers, then resolution into three states
   always_comb begin
      state_next = state_reg;
      state_next.hi_sync = {state_reg.hi_sync[0], pin_above_hi};
      state_next.lo_sync = {state_reg.lo_sync[0], pin_below_lo};
      // neither threshold crossed, or a contradictory pair, counts as mid
      unique case ({state_reg.hi_sync[1], state_reg.lo_sync[1]})
         2'b10: state_next.level = AMD_LVL_HIGH;
         2'b01: state_next.level = AMD_LVL_LOW;
         default: state_next.level = AMD_LVL_MID;
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg.hi_sync <= AMD_SYNC_RST;
         state_reg.lo_sync <= AMD_SYNC_RST;
         state_reg.level <= AMD_LVL_MID;
      end else begin
         state_reg <= state_next;
      end
   end

   assign level = state_reg.level;

endmodule // amd_tri_level
`default_nettype wire

// file: verif/amd_mode_decode_tb.sv
`default_nettype none
module amd_mode_decode_tb
   import amd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] lv = 8'h55;
   logic [7:0] cmp;
   logic sample_clk_p = 1'b1;
   logic [7:0] fs_adjust_reg = 8'h00;
   logic ext_ctl_active, alt_extended_ctl_enable, fs_range_high, fs_use_register;
   logic [7:0] fs_adjust;
   logic sync_differential, out_clock_sync_neg, cal_delay_long, serial_chip_select_n;
   logic dual_edge_sampling, sample_take;
   logic [1:0] lv3 [3] = '{AMD_LVL_LOW, AMD_LVL_MID, AMD_LVL_HIGH};
   int bad_count = 0;
   int checks = 0;
   int takes = 0;

   // ****************************************
   // design and pin strapping
   // ****************************************
   amd_pin_strap amd_pin_strap_inst (.lv(lv), .cmp(cmp));
   amd_mode_decode amd_mode_decode_inst (
      .clk(clk), .rstn(rstn),
      .extended_ctl_enable_hi(cmp[7]), .extended_ctl_enable_lo(cmp[6]),
      .sync_polarity_select_hi(cmp[5]), .sync_polarity_select_lo(cmp[4]),
      .full_scale_select_hi(cmp[3]), .full_scale_select_lo(cmp[2]),
      .cal_delay_select_hi(cmp[1]), .cal_delay_select_lo(cmp[0]),
      .sample_clk_p(sample_clk_p), .fs_adjust_reg(fs_adjust_reg),
      .ext_ctl_active(ext_ctl_active), .alt_extended_ctl_enable(alt_extended_ctl_enable),
      .fs_range_high(fs_range_high), .fs_use_register(fs_use_register),
      .fs_adjust(fs_adjust), .sync_differential(sync_differential),
      .out_clock_sync_neg(out_clock_sync_neg), .cal_delay_long(cal_delay_long),
      .serial_chip_select_n(serial_chip_select_n),
      .dual_edge_sampling(dual_edge_sampling), .sample_take(sample_take));

   // ****************************************
   // clock, pulse counter, watchdog
   // ****************************************
   initial begin
      forever #5 clk = ~clk;
   end
   // counts one-cycle sample pulses, looked at mid-cycle where they stand
   always @(negedge clk) begin
      if (sample_take === 1'b1) takes++;
   end
   // cuts a hang short after far more than the tests need
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      wrap_up();
   end

   // ****************************************
   // compare and access tasks
   // ****************************************
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   // reset, check held values, release, check first mid-level decode
   task automatic do_reset();
      @(negedge clk);
      rstn = 1'b0;
      repeat (6) @(negedge clk);
      chk1(ext_ctl_active, 1'b0);
      chk1(fs_range_high, 1'b1);
      chk1(serial_chip_select_n, 1'b1);
      chk8(fs_adjust, 8'h00);
      chk1(sample_take, 1'b0);
      rstn = 1'b1;
      @(negedge clk);
      chk1(dual_edge_sampling, 1'b1);
      chk1(ext_ctl_active, 1'b1);
      repeat (6) @(negedge clk);
      $display("test reset done");
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      logic [1:0] e, s, f, c;
      logic dif, alt, ext;
      logic [7:0] r;
      do_reset();
      // every level on every pin, with a changing adjust value
      for (int n = 0; n < 81; n++) begin
         e = lv3[n/27];
         s = lv3[(n/9)%3];
         f = lv3[(n/3)%3];
         c = lv3[n%3];
         r = 8'h5a ^ 8'(n);
         lv = {e, s, f, c};
         fs_adjust_reg = r;
         repeat (6) @(negedge clk);
         dif = (s == AMD_LVL_LOW);
         alt = !dif && (f == AMD_LVL_MID);
         ext = (e == AMD_LVL_LOW) || ((e == AMD_LVL_MID) && alt);
         chk1(ext_ctl_active, ext);
         chk1(alt_extended_ctl_enable, alt);
         chk1(fs_range_high, dif || (f != AMD_LVL_LOW));
         chk1(fs_use_register, ext);
         chk8(fs_adjust, ext ? r : 8'h00);
         chk1(sync_differential, dif);
         chk1(out_clock_sync_neg, dif && (f == AMD_LVL_HIGH));
         chk1(cal_delay_long, !alt && (c == AMD_LVL_HIGH));
         chk1(serial_chip_select_n, !alt || (c != AMD_LVL_LOW));
         chk1(dual_edge_sampling, c == AMD_LVL_MID);
      end
      $display("test decode done");
      // five falls of the sample clock give five pulses, rises give none
      takes = 0;
      for (int k = 0; k < 5; k++) begin
         sample_clk_p = 1'b0;
         repeat (4) @(negedge clk);
         sample_clk_p = 1'b1;
         repeat (4) @(negedge clk);
      end
      repeat (6) @(negedge clk);
      chk8(8'(takes), 8'h05);
      $display("test sampling done");
      do_reset();
      wrap_up();
   end
endmodule // amd_mode_decode_tb
`default_nettype wire

// file: verif/amd_pin_strap.sv
`default_nettype none
module amd_pin_strap
   import amd_pkg::*;
(
   // strapped levels: enable, sync polarity, shared, cal delay
   input wire logic [7:0] lv,
   // comparator pairs {hi, lo} per pin
   output var logic [7:0] cmp
);
   timeunit 1ns;
   timeprecision 1ps;
   // a floating pin sits at mid supply, so neither comparator trips
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         cmp[2*k+1] = (lv[2*k+:2] == AMD_LVL_HIGH);
         cmp[2*k] = (lv[2*k+:2] == AMD_LVL_LOW);
      end
   end
endmodule // amd_pin_strap
`default_nettype wire
